/* time_scale_pkg.sv */
`default_nettype none
package time_scale_pkg;
  // Clock and derived rates
  localparam int CLK_HZ = 200_000_000;
  localparam int TICK_HZ = 10_000_000;
  localparam int TICK_DIV = CLK_HZ / TICK_HZ;
  localparam int TICK_W = 5;
  localparam int SCAN_HZ = 10_000;
  localparam int SCAN_DIV_DEF = CLK_HZ / SCAN_HZ;
  localparam int SCAN_W = 15;
  localparam int PULSE_MS = 15;
  localparam int PULSE_CYC_DEF = (CLK_HZ / 1000) * PULSE_MS;
  localparam int PULSE_W = 22;
  // Divider shape
  localparam int NDEC = 7;
  localparam int DIG_W = 4;
  localparam logic [3:0] LAST_DIGIT = 4'h9;
  localparam logic [3:0] ADV_STATE = 4'h8;
  localparam int AUX_10HZ_DEC = 5;
  localparam int AUX_1HZ_DEC = 6;
  // Correction select 0..3 maps to the aux decade index
  localparam logic [3:0][2:0] CORR_MAP = {3'h6, 3'h5, 3'h4, 3'h0};
  // APB map
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CORR = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_SNAP = 8'h0c;
  localparam int CTRL_RATE_BIT = 0;
  localparam int CORR_SEL_LSB = 0;
  localparam int CORR_DIR_BIT = 2;
  localparam int STAT_START_BIT = 0;
  localparam int STAT_PEND_BIT = 1;
  localparam int STAT_ARM_BIT = 2;
  localparam logic CTRL_RATE_RST = 1'b0;
  typedef enum logic {CORR_RETARD, CORR_ADVANCE} corr_dir_t;
endpackage : time_scale_pkg
`default_nettype wire

/* decade_counter.sv */
`default_nettype none
module decade_counter
  import time_scale_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Count control
  input wire logic inc,
  input wire logic supp,
  input wire logic adv,
  // State and carry
  output logic [3:0] count,
  output logic carry,
  output logic taken
);
  logic [3:0] count_r;
  logic [3:0] count_nxt;
  logic early;

  assign early = adv && (count_r == ADV_STATE);
  assign taken = inc && (supp || early);
  // Carry is combinational so the next decade steps on the same edge
  assign carry = inc && !supp && ((count_r == LAST_DIGIT) || early);
  assign count = count_r;

  always_comb begin
    count_nxt = count_r;
    if (inc && !supp) begin
      if (early || count_r == LAST_DIGIT) begin
        count_nxt = 4'h0;
      end else begin
        count_nxt = count_r + 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= 4'h0;
    end else begin
      count_r <= count_nxt;
    end
  end
endmodule : decade_counter
`default_nettype wire

/* time_scale_divider.sv */
`default_nettype none
// Operation
// - Block clock to divider until start
// - Start latched, no stop path
// - Seven decades divide 10 MHz to 1 Hz
// - Interrogation copies decades into buffer
// - Two capture strobes, 10 and 1 MHz aligned
// - Fast strobe first decade, slow the rest
// - Buffered digits multiplexed onto 1-2-4-8 lines
// - Shift register scan at 10 kHz
// - Scan selects steer mux and digit drivers
// - Aux divider one plus six decades
// - Retard suppresses one input pulse
// - Advance zeroes decade at state 8
// - Same corrections at 1, 10, 100 ms
// - Carry bypass much faster than decade
// - Selector picks 10 Hz or 1 Hz
// - Output pulses stretched to 15 ms
// - Outputs retimed on 10 MHz clock
module time_scale_divider
  import time_scale_pkg::*;
#(
  parameter int SCAN_DIV = SCAN_DIV_DEF,
  parameter int PULSE_CYC = PULSE_CYC_DEF
)(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [time_scale_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Control pins
  input wire logic start,
  input wire logic interrogate,
  // Display
  output logic [3:0] bcd,
  output logic [time_scale_pkg::NDEC-1:0] digit_en,
  // Time scale outputs
  output logic main_ts,
  output logic aux_ts
);
  import time_scale_pkg::*;

  logic [TICK_W-1:0] tick_cnt_r;
  logic tick;
  logic tick_d_r;
  logic started_r;
  logic [NDEC-1:0] m_inc, m_carry;
  logic [NDEC-1:0][3:0] m_cnt;
  logic [NDEC-1:0] a_inc, a_carry, a_supp, a_adv, a_taken;
  logic [NDEC-1:0][3:0] a_cnt;
  logic [NDEC-1:0][3:0] snap_r;
  logic irq_prev_r, q1_arm_r, q2_arm_r, c0_d_r;
  logic irq_rise, q1_stb, q2_stb;
  logic [SCAN_W-1:0] scan_cnt_r;
  logic [NDEC-1:0] scan_r;
  logic [3:0] bcd_r;
  logic [3:0] sel_digit;
  logic rate_sel_r;
  logic corr_pend_r;
  corr_dir_t corr_dir_r;
  logic [2:0] corr_dec_r;
  logic corr_done;
  logic aux_src;
  logic [PULSE_W-1:0] main_hold_r, aux_hold_r;
  logic main_ts_r, aux_ts_r;
  logic [31:0] prdata_r;
  logic wr_en, setup, addr_ok;

  ////////////////////////////////////////////////////////////////////////////
  // 10 MHz tick and start gate
  assign tick = (tick_cnt_r == TICK_W'(TICK_DIV - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= '0;
      tick_d_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick ? '0 : tick_cnt_r + TICK_W'(1);
      tick_d_r <= tick;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      started_r <= 1'b0;
    end else if (start) begin
      started_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main and auxiliary dividers
  // gate clock pulses
  assign m_inc[0] = tick && started_r;
  assign a_inc[0] = tick;

  genvar k;
  generate
    for (k = 0; k < NDEC; k++) begin : g_dec
      if (k > 0) begin : g_chain
        assign m_inc[k] = m_carry[k-1];
        assign a_inc[k] = a_carry[k-1];
      end
      assign a_adv[k] = corr_pend_r && (corr_dec_r == 3'(k)) &&
                        (corr_dir_r == CORR_ADVANCE);
      assign a_supp[k] = corr_pend_r && (corr_dec_r == 3'(k)) &&
                         (corr_dir_r == CORR_RETARD);
      decade_counter u_main (
        .pclk(pclk),
        .presetn(presetn),
        .inc(m_inc[k]),
        .supp(1'b0),
        .adv(1'b0),
        .count(m_cnt[k]),
        .carry(m_carry[k]),
        .taken()
      );
      decade_counter u_aux (
        .pclk(pclk),
        .presetn(presetn),
        .inc(a_inc[k]),
        .supp(a_supp[k]),
        .adv(a_adv[k]),
        .count(a_cnt[k]),
        .carry(a_carry[k]),
        .taken(a_taken[k])
      );
    end
  endgenerate

  assign corr_done = |a_taken;

  ////////////////////////////////////////////////////////////////////////////
  // Interrogation capture
  assign irq_rise = interrogate && !irq_prev_r;
  // strobes follow a 10 MHz step or a 1 MHz carry
  assign q1_stb = q1_arm_r && tick_d_r;
  assign q2_stb = q2_arm_r && (c0_d_r || (!started_r && tick_d_r));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_prev_r <= 1'b0;
      q1_arm_r <= 1'b0;
      q2_arm_r <= 1'b0;
      c0_d_r <= 1'b0;
    end else begin
      irq_prev_r <= interrogate;
      // New request wins over the clearing strobe
      q1_arm_r <= irq_rise || (q1_arm_r && !q1_stb);
      q2_arm_r <= irq_rise || (q2_arm_r && !q2_stb);
      c0_d_r <= m_carry[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snap_r <= '0;
    end else begin
      if (q1_stb) begin
        snap_r[0] <= m_cnt[0];
      end
      if (q2_stb) begin
        snap_r[NDEC-1:1] <= m_cnt[NDEC-1:1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Display scan
  always_comb begin
    sel_digit = 4'h0;
    for (int i = 0; i < NDEC; i++) begin
      if (scan_r[i]) begin
        sel_digit = snap_r[i];
      end
    end
  end

  // one-hot shift register at 10 kHz
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_cnt_r <= '0;
      scan_r <= NDEC'(1);
    end else if (scan_cnt_r == SCAN_W'(SCAN_DIV - 1)) begin
      scan_cnt_r <= '0;
      scan_r <= {scan_r[NDEC-2:0], scan_r[NDEC-1]};
    end else begin
      scan_cnt_r <= scan_cnt_r + SCAN_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcd_r <= 4'h0;
    end else begin
      bcd_r <= sel_digit;
    end
  end

  assign bcd = bcd_r;
  assign digit_en = scan_r;

  ////////////////////////////////////////////////////////////////////////////
  // Output pulse forming
  // rate selector
  assign aux_src = rate_sel_r ? a_carry[AUX_10HZ_DEC] : a_carry[AUX_1HZ_DEC];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_hold_r <= '0;
      aux_hold_r <= '0;
    end else begin
      if (m_carry[NDEC-1]) begin
        main_hold_r <= PULSE_W'(PULSE_CYC);
      end else if (main_hold_r != '0) begin
        main_hold_r <= main_hold_r - PULSE_W'(1);
      end
      if (aux_src) begin
        aux_hold_r <= PULSE_W'(PULSE_CYC);
      end else if (aux_hold_r != '0) begin
        aux_hold_r <= aux_hold_r - PULSE_W'(1);
      end
    end
  end

  // retime on 10 MHz tick, costs up to one tick of latency
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_ts_r <= 1'b0;
      aux_ts_r <= 1'b0;
    end else if (tick) begin
      main_ts_r <= (main_hold_r != '0);
      aux_ts_r <= (aux_hold_r != '0);
    end
  end

  assign main_ts = main_ts_r;
  assign aux_ts = aux_ts_r;

  ////////////////////////////////////////////////////////////////////////////
  // APB registers
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite;
  assign addr_ok = (paddr == OFF_CTRL) || (paddr == OFF_CORR) ||
                   (paddr == OFF_STAT) || (paddr == OFF_SNAP);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata = prdata_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_sel_r <= CTRL_RATE_RST;
    end else if (wr_en && paddr == OFF_CTRL) begin
      rate_sel_r <= pwdata[CTRL_RATE_BIT];
    end
  end

  // one application per write; new write wins over completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      corr_pend_r <= 1'b0;
      corr_dir_r <= CORR_RETARD;
      corr_dec_r <= 3'h0;
    end else if (wr_en && paddr == OFF_CORR) begin
      corr_pend_r <= 1'b1;
      corr_dir_r <= corr_dir_t'(pwdata[CORR_DIR_BIT]);
      corr_dec_r <= CORR_MAP[pwdata[CORR_SEL_LSB +: 2]];
    end else if (corr_done) begin
      corr_pend_r <= 1'b0;
    end
  end

  // Read data latched in setup so it comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0;
    end else if (setup) begin
      prdata_r <= 32'h0;
      case (paddr)
        OFF_CTRL: prdata_r[CTRL_RATE_BIT] <= rate_sel_r;
        OFF_CORR: prdata_r[CORR_DIR_BIT:0] <= {corr_dir_r, 2'h0};
        OFF_STAT: prdata_r[STAT_ARM_BIT:0] <=
          {q1_arm_r || q2_arm_r, corr_pend_r, started_r};
        OFF_SNAP: prdata_r[NDEC*DIG_W-1:0] <= snap_r;
        default: prdata_r <= 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_no_count;
    @(posedge pclk) disable iff (!presetn) !started_r |-> m_cnt == '0;
  endproperty
  a_no_count: assert property (p_no_count)
    else $error("main divider moved before start");

  property p_start_held;
    @(posedge pclk) disable iff (!presetn) started_r |=> started_r;
  endproperty
  a_start_held: assert property (p_start_held)
    else $error("start latch dropped");

  property p_one_hz;
    @(posedge pclk) disable iff (!presetn)
      (m_inc[0] && m_cnt == {NDEC{4'h9}}) |-> m_carry[NDEC-1] ##1 m_cnt == '0;
  endproperty
  a_one_hz: assert property (p_one_hz)
    else $error("main divider did not wrap to 1 Hz");

  property p_fast_cap;
    @(posedge pclk) disable iff (!presetn)
      q1_stb |=> snap_r[0] == $past(m_cnt[0]);
  endproperty
  a_fast_cap: assert property (p_fast_cap)
    else $error("first decade not captured");

  property p_slow_align;
    @(posedge pclk) disable iff (!presetn)
      (q2_stb && started_r) |-> $past(m_carry[0]);
  endproperty
  a_slow_align: assert property (p_slow_align)
    else $error("slow strobe not after 1 MHz carry");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
      (!q1_stb && !q2_stb) |=> $stable(snap_r);
  endproperty
  a_hold: assert property (p_hold)
    else $error("buffer changed without strobe");

  property p_scan;
    @(posedge pclk) disable iff (!presetn)
      $onehot(scan_r) && digit_en == scan_r;
  endproperty
  a_scan: assert property (p_scan)
    else $error("scan select not one-hot");

  property p_bcd;
    @(posedge pclk) disable iff (!presetn)
      // Lines lag the select by one cycle, so only check a settled pair
      ($stable(scan_r) && $stable(snap_r)) |-> bcd == sel_digit;
  endproperty
  a_bcd: assert property (p_bcd)
    else $error("bcd lines not the selected digit");

  property p_retard;
    @(posedge pclk) disable iff (!presetn)
      (a_inc[0] && a_supp[0]) |=> a_cnt[0] == $past(a_cnt[0]) && !corr_pend_r;
  endproperty
  a_retard: assert property (p_retard)
    else $error("retard did not swallow one pulse");

  property p_advance;
    @(posedge pclk) disable iff (!presetn)
      (a_inc[0] && a_adv[0] && a_cnt[0] == ADV_STATE) |-> a_carry[0]
        ##1 a_cnt[0] == 4'h0;
  endproperty
  a_advance: assert property (p_advance)
    else $error("advance did not restart at 8");

  property p_stretch;
    @(posedge pclk) disable iff (!presetn)
      m_carry[NDEC-1] |=> main_hold_r == PULSE_W'(PULSE_CYC);
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("pulse width not loaded");

  property p_retime;
    @(posedge pclk) disable iff (!presetn)
      ($changed(main_ts) || $changed(aux_ts)) |-> $past(tick);
  endproperty
  a_retime: assert property (p_retime)
    else $error("output changed off the 10 MHz tick");
endmodule : time_scale_divider
`default_nettype wire

/* ts_partner.sv */
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// Interrogation source and multiplexed digit display
module ts_partner (
  // Clock
  input wire logic pclk,
  // Source control
  input wire logic fire,
  output logic interrogate,
  // Display lines
  input wire logic [3:0] bcd,
  input wire logic [6:0] digit_en,
  output logic [27:0] shown
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] hold_r;
  initial begin
    hold_r = 2'h0;
    shown = 28'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // pulse at any time
  // Held three cycles, the device must act once on the rising edge only
  always @(posedge pclk) begin
    if (fire) begin
      hold_r <= 2'h3;
    end else if (hold_r != 2'h0) begin
      hold_r <= hold_r - 2'h1;
    end
  end
  assign interrogate = (hold_r != 2'h0);
  ////////////////////////////////////////////////////////////////////////////
  // digit per enable
  // Last bcd seen while a position is enabled stays on that digit
  always @(posedge pclk) begin
    for (int i = 0; i < 7; i++) begin
      if (digit_en[i]) begin
        shown[4*i +: 4] <= bcd;
      end
    end
  end
endmodule : ts_partner
`default_nettype wire

/* test_time_scale_divider.sv */
`default_nettype none
module test_time_scale_divider
  import time_scale_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Short counts keep the run small
  localparam int SD = 8;
  localparam int PC = 100;
  logic pclk, presetn, psel, penable, pwrite, start, fire, interrogate;
  logic pready, pslverr, main_ts, aux_ts, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, s1, s2;
  logic [3:0] bcd;
  logic [6:0] digit_en;
  logic [27:0] shown;
  int miscompares, total_checks, cycles, n;

  always #2.5 pclk = ~pclk;

  time_scale_divider #(.SCAN_DIV(SD), .PULSE_CYC(PC)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .start(start),
    .interrogate(interrogate), .bcd(bcd), .digit_en(digit_en),
    .main_ts(main_ts), .aux_ts(aux_ts)
  );
  ts_partner far_side (
    .pclk(pclk), .fire(fire), .interrogate(interrogate), .bcd(bcd),
    .digit_en(digit_en), .shown(shown)
  );
  ////////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task conclude;
    if (miscompares == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  // Request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rchk

  task wait_n(input int k);
    repeat (k) @(posedge pclk);
  endtask : wait_n

  task ask;
    @(posedge pclk);
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
  endtask : ask

  function automatic int snap_val(input logic [31:0] s);
    int v;
    v = 0;
    for (int i = 6; i >= 0; i--) begin
      v = v * 10 + int'(s[4*i +: 4]);
    end
    return v;
  endfunction : snap_val
  ////////////////////////////////////////////////////////////////////////////
  // A hang counts as a mismatch
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      conclude();
    end
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    start = 1'b0;
    fire = 1'b0;
    miscompares = 0;
    total_checks = 0;
    cycles = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rchk(OFF_STAT, 32'h0);
    ask();
    wait_n(300);
    rchk(OFF_SNAP, 32'h0);
    @(posedge pclk);
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    wait_n(50);
    rchk(OFF_STAT, 32'h1);
    // Requests 2000 cycles apart: exactly 100 ticks between snapshots
    n = cycles;
    ask();
    wait_n(300);
    apb(1'b0, OFF_SNAP, 32'h0);
    s1 = rd;
    // Spacing counted on the cycle counter, not on bus latency
    while (cycles != n + 2000) @(posedge pclk);
    ask();
    wait_n(300);
    apb(1'b0, OFF_SNAP, 32'h0);
    s2 = rd;
    n = (snap_val(s2) + 10000000 - snap_val(s1)) % 10000000;
    check(32'(n), 32'd100);
    wait_n(500);
    rchk(OFF_SNAP, s2);
    check({4'h0, shown}, s2);
    rd = {25'h0, digit_en};
    while (digit_en === rd[6:0]) @(posedge pclk);
    rd = {25'h0, digit_en};
    n = 0;
    while (digit_en === rd[6:0] && n < 100) begin
      @(posedge pclk);
      n++;
    end
    check(32'(n), 32'(SD));
    check({31'h0, $onehot(digit_en)}, 32'h1);
    rchk(OFF_CTRL, 32'h0);
    apb(1'b1, OFF_CTRL, 32'h1);
    rchk(OFF_CTRL, 32'h1);
    apb(1'b1, OFF_STAT, 32'hff);
    rchk(OFF_STAT, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    check({err, rd[30:0]}, 32'h8000_0000);
    // All four correction decades and both directions; later decades stay pending this early
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, OFF_CORR, 32'(i));
      rchk(OFF_CORR, 32'(i & 4));
      wait_n(250);
      rchk(OFF_STAT, (i % 4 == 0) ? 32'h1 : 32'h3);
    end
    check({30'h0, main_ts, aux_ts}, 32'h0);
    conclude();
  end
endmodule : test_time_scale_divider
`default_nettype wire
